// file: src/lwn_port_ctrl.sv
// Per-port link width and speed negotiation policy with Avalon-MM registers
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps

module lwn_port_ctrl #(
  parameter int MAX_LANES = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic PORT_DOWNSTREAM_I,
  input wire logic LTSSM_DETECT_I,
  input wire logic LTSSM_CONFIG_I,
  input wire logic [MAX_LANES-1:0] LANE_GOOD_I,
  input wire logic CFG_ANSWER_I,
  input wire logic [5:0] PARTNER_WIDTH_I,
  input wire logic PARTNER_REVERSED_I,
  input wire logic LANE_NUM_FAIL_I,
  input wire logic RESIZE_REQ_I,
  input wire logic PARTNER_AUTON_I,
  input wire logic RX_RATES_VALID_I,
  input wire logic [1:0] RX_RATES_I,
  input wire logic LTSSM_L0_I,
  input wire logic DL_ACTIVE_I,
  input wire logic SPEED_DONE_I,
  input wire logic SPEED_OK_I,
  input wire logic PARTNER_SPEED_I,
  input wire logic PARTNER_GEN2_I,
  input wire logic RELIAB_DOWN_I,
  output logic GO_DETECT_O,
  output logic [5:0] TX_WIDTH_O,
  output logic TX_REVERSED_O,
  output logic RESIZE_OK_O,
  output logic [1:0] TX_RATES_O,
  output logic TX_AUTON_CHANGE_O,
  output logic SPEED_REQ_O,
  output logic REQ_GEN2_O
);

  initial
  begin
    if (!(MAX_LANES == 1 || MAX_LANES == 2 || MAX_LANES == 4 ||
          MAX_LANES == 8))
      $error("MAX_LANES must be 1, 2, 4 or 8");
  end

  localparam logic [5:0] MAX_W = 6'(MAX_LANES);

  // ==========================================================
  // Lane helpers
  function automatic logic [5:0] run_low(input logic [MAX_LANES-1:0] v);
    logic [5:0] n;
    logic stop;
    n = 6'h00;
    stop = 1'b0;
    for (int i = 0; i < MAX_LANES; i++)
    begin
      if (!v[i])
        stop = 1'b1;
      else if (!stop)
        n = n + 6'h01;
    end
    return n;
  endfunction

  function automatic logic [5:0] run_high(input logic [MAX_LANES-1:0] v);
    logic [5:0] n;
    logic stop;
    n = 6'h00;
    stop = 1'b0;
    for (int i = MAX_LANES - 1; i >= 0; i--)
    begin
      if (!v[i])
        stop = 1'b1;
      else if (!stop)
        n = n + 6'h01;
    end
    return n;
  endfunction

  function automatic logic legal_w(input logic [5:0] w);
    return (w == 6'h01 || w == 6'h02 || w == 6'h04 || w == 6'h08) &&
           w <= MAX_W;
  endfunction

  // Largest legal width within both the lane run and the limit
  function automatic logic [5:0] fit_w(input logic [5:0] n,
                                       input logic [5:0] lim);
    logic [5:0] m;
    m = (n < lim) ? n : lim;
    if (m >= 6'h08)
      return 6'h08;
    else if (m >= 6'h04)
      return 6'h04;
    else if (m >= 6'h02)
      return 6'h02;
    else
      return m;
  endfunction

  // ==========================================================
  // State
  logic ack;
  logic [5:0] max_link_width_field;
  logic [5:0] active_max;
  logic register_unlock_bit;
  logic [5:0] negotiated_width_field;
  logic link_reversed;
  logic rev_allowed;
  logic bw_mgmt_status;
  logic autonomous_bandwidth_status;
  logic [3:0] target_speed_field;
  logic [3:0] cur_speed;
  logic initial_speed_change_inhibit;
  logic [1:0] partner_rates;
  logic init_pend;
  logic retrain_pend;
  lwn_pkg::lwn_speed_state_t sp_state;
  logic [31:0] be_mask;
  logic [31:0] cur_word;
  logic [31:0] wr_word;
  logic [31:0] clr_word;
  logic wr_go;
  logic [5:0] low_run;
  logic [5:0] high_run;
  logic [5:0] low_fit;
  logic [5:0] high_fit;
  logic cfg_ok;
  logic num_fail;
  logic link_up;
  logic partner_gen2;
  logic target_gen2;
  logic wr_cap;
  logic wr_ctl;
  logic wr_sts;
  logic wr_ctl2;
  logic wr_phy;

  // ==========================================================
  // Avalon-MM slave: one wait cycle, then answer
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;
  assign wr_go = AVS_WRITE_I & ack;
  assign wr_cap = wr_go && AVS_ADDRESS_I == lwn_pkg::OFF_LINK_CAP;
  assign wr_ctl = wr_go && AVS_ADDRESS_I == lwn_pkg::OFF_LINK_CTL;
  assign wr_sts = wr_go && AVS_ADDRESS_I == lwn_pkg::OFF_LINK_STS;
  assign wr_ctl2 = wr_go && AVS_ADDRESS_I == lwn_pkg::OFF_LINK_CTL2;
  assign wr_phy = wr_go && AVS_ADDRESS_I == lwn_pkg::OFF_PHY_STATE;

  always_comb
  begin
    for (int b = 0; b < 4; b++)
      be_mask[b*8 +: 8] = {8{AVS_BYTEENABLE_I[b]}};
  end

  always_comb
  begin
    cur_word = 32'h0000_0000;
    unique case (AVS_ADDRESS_I)
      lwn_pkg::OFF_LINK_CAP:
      begin
        cur_word[lwn_pkg::CAP_SPEED_LSB +: 4] = lwn_pkg::SPEED_GEN2;
        cur_word[lwn_pkg::CAP_WIDTH_LSB +: 6] = max_link_width_field;
      end
      lwn_pkg::OFF_SW_CTL:
        cur_word[lwn_pkg::SW_UNLOCK_BIT] = register_unlock_bit;
      lwn_pkg::OFF_LINK_CTL:
        cur_word[lwn_pkg::CTL_HW_AUTONOMOUS_WIDTH_DISABLE_BIT] = 1'b0;
      lwn_pkg::OFF_LINK_STS:
      begin
        cur_word[lwn_pkg::STS_SPEED_LSB +: 4] = cur_speed;
        cur_word[lwn_pkg::STS_WIDTH_LSB +: 6] = negotiated_width_field;
        cur_word[lwn_pkg::STS_BW_MGMT_BIT] = bw_mgmt_status;
        cur_word[lwn_pkg::STS_AUTON_BW_BIT] = autonomous_bandwidth_status;
      end
      lwn_pkg::OFF_LINK_CTL2:
        cur_word[lwn_pkg::CTL2_TARGET_LSB +: 4] = target_speed_field;
      lwn_pkg::OFF_PHY_STATE:
      begin
        cur_word[lwn_pkg::PHY_INHIBIT_BIT] = initial_speed_change_inhibit;
        cur_word[lwn_pkg::PHY_REVERSED_BIT] = link_reversed;
        cur_word[lwn_pkg::PHY_PARTNER_LSB +: 2] = partner_rates;
      end
      default:
        cur_word = 32'h0000_0000;
    endcase
  end

  assign wr_word = (cur_word & ~be_mask) | (AVS_WRITEDATA_I & be_mask);
  assign clr_word = AVS_WRITEDATA_I & be_mask;

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ack <= 1'b0;
      AVS_READDATA_O <= 32'h0000_0000;
    end
    else
    begin
      ack <= (AVS_READ_I | AVS_WRITE_I) & ~ack;
      if (AVS_READ_I && !ack)
        AVS_READDATA_O <= cur_word;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      max_link_width_field <= MAX_W;
      register_unlock_bit <= lwn_pkg::UNLOCK_RESET;
      target_speed_field <= lwn_pkg::TARGET_RESET;
      initial_speed_change_inhibit <= lwn_pkg::INHIBIT_RESET;
    end
    else
    begin
      if (wr_go && AVS_ADDRESS_I == lwn_pkg::OFF_SW_CTL)
        register_unlock_bit <= wr_word[lwn_pkg::SW_UNLOCK_BIT];
      if (wr_cap && register_unlock_bit &&
          legal_w(wr_word[lwn_pkg::CAP_WIDTH_LSB +: 6]))
        max_link_width_field <= wr_word[lwn_pkg::CAP_WIDTH_LSB +: 6];
      if (wr_ctl2 && (wr_word[3:0] == lwn_pkg::SPEED_GEN1 ||
                      wr_word[3:0] == lwn_pkg::SPEED_GEN2))
        target_speed_field <= wr_word[lwn_pkg::CTL2_TARGET_LSB +: 4];
      if (wr_phy)
        initial_speed_change_inhibit <= wr_word[lwn_pkg::PHY_INHIBIT_BIT];
    end
  end

  // ==========================================================
  // Width negotiation and lane reversal
  assign low_run = run_low(LANE_GOOD_I);
  assign high_run = run_high(LANE_GOOD_I);
  assign low_fit = fit_w(low_run, active_max);
  assign high_fit = fit_w(high_run, active_max);
  assign cfg_ok = legal_w(PARTNER_WIDTH_I) &&
                  PARTNER_WIDTH_I <= active_max &&
                  (PARTNER_REVERSED_I ?
                   (rev_allowed && PARTNER_WIDTH_I <= high_run) :
                   PARTNER_WIDTH_I <= low_run);
  assign num_fail = LANE_NUM_FAIL_I | (CFG_ANSWER_I & ~cfg_ok);

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      active_max <= MAX_W;
      rev_allowed <= 1'b1;
      TX_WIDTH_O <= 6'h00;
      TX_REVERSED_O <= 1'b0;
      negotiated_width_field <= 6'h00;
      link_reversed <= 1'b0;
      GO_DETECT_O <= 1'b0;
      RESIZE_OK_O <= 1'b0;
    end
    else
    begin
      GO_DETECT_O <= (wr_phy && wr_word[lwn_pkg::PHY_FULL_RETRAIN_BIT]) ||
                     num_fail;
      RESIZE_OK_O <= 1'b0;
      if (wr_phy && wr_word[lwn_pkg::PHY_FULL_RETRAIN_BIT])
        rev_allowed <= 1'b1;
      else if (num_fail)
        rev_allowed <= 1'b0;
      if (LTSSM_DETECT_I)
      begin
        active_max <= max_link_width_field;
        negotiated_width_field <= 6'h00;
        link_reversed <= 1'b0;
      end
      else if (LTSSM_CONFIG_I)
      begin
        if (PORT_DOWNSTREAM_I && rev_allowed && high_fit > low_fit)
        begin
          TX_WIDTH_O <= high_fit;
          TX_REVERSED_O <= 1'b1;
        end
        else
        begin
          TX_WIDTH_O <= low_fit;
          TX_REVERSED_O <= 1'b0;
        end
      end
      else if (CFG_ANSWER_I && cfg_ok)
      begin
        negotiated_width_field <= PARTNER_WIDTH_I;
        link_reversed <= PARTNER_REVERSED_I;
      end
      else if (RESIZE_REQ_I && legal_w(PARTNER_WIDTH_I) &&
               PARTNER_WIDTH_I <= active_max)
      begin
        negotiated_width_field <= PARTNER_WIDTH_I;
        RESIZE_OK_O <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Rate advertisement and partner record
  assign target_gen2 = target_speed_field == lwn_pkg::SPEED_GEN2;
  assign partner_gen2 = partner_rates[1];
  assign TX_RATES_O = {target_gen2, 1'b1};
  assign TX_AUTON_CHANGE_O = 1'b0;
  assign link_up = LTSSM_L0_I & DL_ACTIVE_I;

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      partner_rates <= lwn_pkg::PARTNER_RATES_RESET;
    else if (RX_RATES_VALID_I)
      partner_rates <= RX_RATES_I | 2'h1;
    else if (PARTNER_SPEED_I && PARTNER_GEN2_I)
      partner_rates <= 2'h3;
  end

  // ==========================================================
  // Speed change sequencer
  assign SPEED_REQ_O = sp_state == lwn_pkg::SP_REQ;

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      sp_state <= lwn_pkg::SP_IDLE;
      init_pend <= 1'b0;
      retrain_pend <= 1'b0;
      REQ_GEN2_O <= 1'b0;
    end
    else if (LTSSM_DETECT_I)
    begin
      sp_state <= lwn_pkg::SP_IDLE;
      init_pend <= 1'b1;
      retrain_pend <= 1'b0;
    end
    else
    begin
      if (wr_ctl && wr_word[lwn_pkg::CTL_RETRAIN_BIT] && PORT_DOWNSTREAM_I)
        retrain_pend <= 1'b1;
      unique case (sp_state)
        lwn_pkg::SP_IDLE:
        begin
          if (link_up && retrain_pend)
          begin
            retrain_pend <= 1'b0;
            if (target_speed_field != cur_speed)
            begin
              // Lower of target and common speed
              REQ_GEN2_O <= target_gen2 && partner_gen2;
              if ((target_gen2 && partner_gen2) !=
                  (cur_speed == lwn_pkg::SPEED_GEN2))
                sp_state <= lwn_pkg::SP_REQ;
            end
          end
          else if (link_up && init_pend && PORT_DOWNSTREAM_I &&
                   !initial_speed_change_inhibit && target_gen2 &&
                   partner_gen2 && cur_speed == lwn_pkg::SPEED_GEN1)
          begin
            init_pend <= 1'b0;
            REQ_GEN2_O <= 1'b1;
            sp_state <= lwn_pkg::SP_REQ;
          end
        end
        lwn_pkg::SP_REQ:
        begin
          init_pend <= 1'b0;
          sp_state <= lwn_pkg::SP_WAIT;
        end
        lwn_pkg::SP_WAIT:
        begin
          if (SPEED_DONE_I)
            sp_state <= lwn_pkg::SP_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Current speed and bandwidth status
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      cur_speed <= lwn_pkg::SPEED_GEN1;
    else if (LTSSM_DETECT_I)
      cur_speed <= lwn_pkg::SPEED_GEN1;
    else if (RELIAB_DOWN_I)
      cur_speed <= lwn_pkg::SPEED_GEN1;
    else if (PARTNER_SPEED_I)
      cur_speed <= PARTNER_GEN2_I ? lwn_pkg::SPEED_GEN2 :
                   lwn_pkg::SPEED_GEN1;
    else if (sp_state == lwn_pkg::SP_WAIT && SPEED_DONE_I && SPEED_OK_I)
      cur_speed <= REQ_GEN2_O ? lwn_pkg::SPEED_GEN2 : lwn_pkg::SPEED_GEN1;
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      bw_mgmt_status <= 1'b0;
      autonomous_bandwidth_status <= 1'b0;
    end
    else
    begin
      bw_mgmt_status <= (bw_mgmt_status &
                         ~(wr_sts & clr_word[lwn_pkg::STS_BW_MGMT_BIT])) |
                        (PORT_DOWNSTREAM_I &
                         ((wr_ctl & wr_word[lwn_pkg::CTL_RETRAIN_BIT]) |
                          RELIAB_DOWN_I |
                          ((PARTNER_SPEED_I | RESIZE_REQ_I) &
                           ~PARTNER_AUTON_I)));
      autonomous_bandwidth_status <= (autonomous_bandwidth_status &
                         ~(wr_sts & clr_word[lwn_pkg::STS_AUTON_BW_BIT])) |
                        (PORT_DOWNSTREAM_I & PARTNER_AUTON_I &
                         (PARTNER_SPEED_I | RESIZE_REQ_I));
    end
  end

endmodule

// file: pkg/lwn_pkg.sv
// Register map, field layout and codes of the link width/speed policy block
package lwn_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_LINK_CAP = 8'h00;
  localparam logic [7:0] OFF_SW_CTL = 8'h04;
  localparam logic [7:0] OFF_LINK_CTL = 8'h08;
  localparam logic [7:0] OFF_LINK_STS = 8'h0c;
  localparam logic [7:0] OFF_LINK_CTL2 = 8'h10;
  localparam logic [7:0] OFF_PHY_STATE = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CAP_SPEED_LSB = 0;
  localparam int CAP_WIDTH_LSB = 4;
  localparam int SW_UNLOCK_BIT = 0;
  localparam int CTL_RETRAIN_BIT = 5;
  localparam int CTL_HW_AUTONOMOUS_WIDTH_DISABLE_BIT = 9;
  localparam int STS_SPEED_LSB = 0;
  localparam int STS_WIDTH_LSB = 4;
  localparam int STS_BW_MGMT_BIT = 14;
  localparam int STS_AUTON_BW_BIT = 15;
  localparam int CTL2_TARGET_LSB = 0;
  localparam int PHY_FULL_RETRAIN_BIT = 0;
  localparam int PHY_INHIBIT_BIT = 1;
  localparam int PHY_REVERSED_BIT = 2;
  localparam int PHY_PARTNER_LSB = 4;

  // ==========================================================
  // Speed codes and reset values
  localparam logic [3:0] SPEED_GEN1 = 4'h1;
  localparam logic [3:0] SPEED_GEN2 = 4'h2;
  localparam logic [3:0] TARGET_RESET = SPEED_GEN2;
  localparam logic [1:0] PARTNER_RATES_RESET = 2'h1;
  localparam logic INHIBIT_RESET = 1'b0;
  localparam logic UNLOCK_RESET = 1'b0;

  typedef enum logic [1:0] {
    SP_IDLE,
    SP_REQ,
    SP_WAIT
  } lwn_speed_state_t;

endpackage

// file: verification/lwn_port_ctrl_props.sv
// Concurrent checks on the port controller pins
`timescale 1ns/1ps
module lwn_port_ctrl_props (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic PORT_DOWNSTREAM_I,
  input wire logic LTSSM_DETECT_I,
  input wire logic LTSSM_CONFIG_I,
  input wire logic RESIZE_REQ_I,
  input wire logic LTSSM_L0_I,
  input wire logic DL_ACTIVE_I,
  input wire logic GO_DETECT_O,
  input wire logic TX_REVERSED_O,
  input wire logic RESIZE_OK_O,
  input wire logic [1:0] TX_RATES_O,
  input wire logic TX_AUTON_CHANGE_O,
  input wire logic SPEED_REQ_O,
  input wire logic REQ_GEN2_O
);
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign rd_ok = AVS_READ_I && !AVS_WAITREQUEST_O;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  // ==========================================================
  // Properties
  property p_auton_zero;
    TX_AUTON_CHANGE_O == 1'b0;
  endproperty
  a_auton_zero: assert property (p_auton_zero) else $error("auton set");
  property p_resize_ok;
    RESIZE_OK_O |-> $past(RESIZE_REQ_I);
  endproperty
  a_resize_ok: assert property (p_resize_ok) else $error("stray ok");
  property p_go_detect;
    wr_ok && AVS_ADDRESS_I == lwn_pkg::OFF_PHY_STATE && AVS_WRITEDATA_I[0]
      && AVS_BYTEENABLE_I[0] |=> GO_DETECT_O;
  endproperty
  a_go_detect: assert property (p_go_detect) else $error("no retrain");
  property p_speed_cond;
    SPEED_REQ_O |-> $past(LTSSM_L0_I) && $past(DL_ACTIVE_I);
  endproperty
  a_speed_cond: assert property (p_speed_cond) else $error("early req");
  property p_gen2_hold;
    $changed(REQ_GEN2_O) |-> SPEED_REQ_O;
  endproperty
  a_gen2_hold: assert property (p_gen2_hold) else $error("rate moved");
  property p_rates_gen1;
    TX_RATES_O[0] == 1'b1;
  endproperty
  a_rates_gen1: assert property (p_rates_gen1) else $error("no gen1");
  property p_hw_autonomous_width_disable_zero;
    rd_ok && AVS_ADDRESS_I == lwn_pkg::OFF_LINK_CTL |-> !AVS_READDATA_O[9];
  endproperty
  a_hw_autonomous_width_disable_zero: assert property (p_hw_autonomous_width_disable_zero) else $error("hw_autonomous_width_disable set");
  property p_up_unrev;
    LTSSM_CONFIG_I && !LTSSM_DETECT_I && !PORT_DOWNSTREAM_I |=> !TX_REVERSED_O;
  endproperty
  a_up_unrev: assert property (p_up_unrev) else $error("up reversed");
  c_gen2_req: cover property (SPEED_REQ_O && REQ_GEN2_O);
  c_resize: cover property (RESIZE_OK_O);
  c_reversed: cover property ($rose(TX_REVERSED_O));
endmodule
bind lwn_port_ctrl lwn_port_ctrl_props u_props (.*);

// file: verification/lwn_partner_model.sv
// Link partner stand-in: rate advert, lane answers, speed completion
`timescale 1ns/1ps
module lwn_partner_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic gen2_cap_i,
  input wire logic [3:0] delay_i,
  input wire logic adv_i,
  input wire logic ans_i,
  input wire logic rsz_i,
  input wire logic [5:0] ans_width_i,
  input wire logic ans_rev_i,
  input wire logic speed_req_i,
  input wire logic req_gen2_i,
  output logic rates_valid_o,
  output logic [1:0] rates_o,
  output logic cfg_answer_o,
  output logic resize_o,
  output logic [5:0] width_o,
  output logic reversed_o,
  output logic speed_done_o,
  output logic speed_ok_o
);
  logic busy;
  logic want_gen2;
  logic [3:0] cnt;
  // ==========================================================
  // Training sets; qualified lines scramble when idle
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {rates_valid_o, cfg_answer_o, resize_o, reversed_o} <= 4'h0;
      rates_o <= 2'h0;
      width_o <= 6'h0;
    end
    else
    begin
      rates_valid_o <= adv_i;
      cfg_answer_o <= ans_i;
      resize_o <= rsz_i;
      rates_o <= adv_i ? {gen2_cap_i, 1'b1} : ~rates_o;
      width_o <= (ans_i || rsz_i) ? ans_width_i : ~width_o;
      reversed_o <= ans_i ? ans_rev_i : ~reversed_o;
    end
  end
  // ==========================================================
  // Speed change, succeeds only at a supported rate
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {busy, want_gen2, speed_done_o, speed_ok_o} <= 4'h0;
      cnt <= 4'h0;
    end
    else
    begin
      speed_done_o <= 1'b0;
      speed_ok_o <= ~speed_ok_o;
      if (speed_req_i && !busy)
      begin
        busy <= 1'b1;
        cnt <= delay_i;
        want_gen2 <= req_gen2_i;
      end
      else if (busy && cnt == 4'h0)
      begin
        busy <= 1'b0;
        speed_done_o <= 1'b1;
        speed_ok_o <= !want_gen2 || gen2_cap_i;
      end
      else if (busy)
        cnt <= cnt - 4'h1;
    end
  end
endmodule

// file: verification/lwn_port_ctrl_bench.sv
// Self-checking bench for the link width and speed policy block
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
    end \
  end
module lwn_port_ctrl_bench;
  logic SYS_CLK_I, RST_B_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O;
  logic [7:0] AVS_ADDRESS_I, LANE_GOOD_I;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O;
  logic [3:0] AVS_BYTEENABLE_I;
  logic PORT_DOWNSTREAM_I, LTSSM_DETECT_I, LTSSM_CONFIG_I, CFG_ANSWER_I;
  logic PARTNER_REVERSED_I, LANE_NUM_FAIL_I, RESIZE_REQ_I, PARTNER_AUTON_I;
  logic RX_RATES_VALID_I, LTSSM_L0_I, DL_ACTIVE_I, SPEED_DONE_I, SPEED_OK_I;
  logic PARTNER_SPEED_I, PARTNER_GEN2_I, RELIAB_DOWN_I, GO_DETECT_O;
  logic TX_REVERSED_O, RESIZE_OK_O, TX_AUTON_CHANGE_O, SPEED_REQ_O, REQ_GEN2_O;
  logic [5:0] PARTNER_WIDTH_I, TX_WIDTH_O, ans_width;
  logic [1:0] RX_RATES_I, TX_RATES_O;
  logic gen2_cap, adv, ans, rsz, ans_rev, seen, g2;
  logic [3:0] delay;
  int error_cnt = 0;
  int tests_run = 0;

  lwn_port_ctrl #(.MAX_LANES(8)) DUT (.*);
  lwn_partner_model u_partner (.clk_i(SYS_CLK_I), .rst_b_i(RST_B_I),
    .gen2_cap_i(gen2_cap), .delay_i(delay), .adv_i(adv), .ans_i(ans),
    .rsz_i(rsz), .ans_width_i(ans_width), .ans_rev_i(ans_rev),
    .speed_req_i(SPEED_REQ_O), .req_gen2_i(REQ_GEN2_O),
    .rates_valid_o(RX_RATES_VALID_I), .rates_o(RX_RATES_I),
    .cfg_answer_o(CFG_ANSWER_I), .resize_o(RESIZE_REQ_I),
    .width_o(PARTNER_WIDTH_I), .reversed_o(PARTNER_REVERSED_I),
    .speed_done_o(SPEED_DONE_I), .speed_ok_o(SPEED_OK_I));

  initial
  begin
    SYS_CLK_I = 1'b0;
    forever #10 SYS_CLK_I = ~SYS_CLK_I;
  end

  task stop_test;
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Bus and link helpers
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    logic wq;
    n = 0;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_WRITE_I <= w;
    AVS_READ_I <= !w;
    // Sample settled values ahead of the edge that ends the wait
    do
    begin
      @(negedge SYS_CLK_I);
      wq = AVS_WAITREQUEST_O;
      q = AVS_READDATA_O;
      @(posedge SYS_CLK_I);
      n++;
    end
    while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0)
      error_cnt++;
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
    @(posedge SYS_CLK_I);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, e, q & m)
  endtask

  task automatic train(input logic [7:0] good);
    LTSSM_L0_I <= 1'b0;
    DL_ACTIVE_I <= 1'b0;
    LANE_GOOD_I <= good;
    LTSSM_DETECT_I <= 1'b1;
    @(posedge SYS_CLK_I);
    LTSSM_DETECT_I <= 1'b0;
    LTSSM_CONFIG_I <= 1'b1;
    @(posedge SYS_CLK_I);
    LTSSM_CONFIG_I <= 1'b0;
    repeat (2) @(posedge SYS_CLK_I);
  endtask

  task automatic msg(input logic r, input logic [5:0] w, input logic rev,
                     input logic au);
    ans_width <= w;
    ans_rev <= rev;
    PARTNER_AUTON_I <= au;
    rsz <= r;
    ans <= !r;
    @(posedge SYS_CLK_I);
    rsz <= 1'b0;
    ans <= 1'b0;
    repeat (3) @(posedge SYS_CLK_I);
  endtask

  task automatic wait_req;
    seen = 1'b0;
    g2 = 1'b0;
    for (int i = 0; i < 12 && !seen; i++)
    begin
      @(negedge SYS_CLK_I);
      seen = SPEED_REQ_O === 1'b1;
      g2 = REQ_GEN2_O;
    end
    @(posedge SYS_CLK_I);
    for (int i = 0; i < 20 && SPEED_DONE_I !== 1'b1; i++)
      @(posedge SYS_CLK_I);
    repeat (2) @(posedge SYS_CLK_I);
  endtask

  task automatic bring_up(input logic [1:0] r);
    train(8'hff);
    msg(1'b0, 6'd8, 1'b0, 1'b0);
    gen2_cap <= r[1];
    adv <= 1'b1;
    @(posedge SYS_CLK_I);
    adv <= 1'b0;
    repeat (2) @(posedge SYS_CLK_I);
    LTSSM_L0_I <= 1'b1;
    DL_ACTIVE_I <= 1'b1;
    wait_req();
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    rd(lwn_pkg::OFF_LINK_CAP, 32'h3ff, 32'h82, "cap");
    rd(lwn_pkg::OFF_LINK_CTL2, 32'hf, 32'h2, "target");
    rd(lwn_pkg::OFF_LINK_STS, 32'hf, 32'h1, "speed");
    rd(lwn_pkg::OFF_PHY_STATE, 32'h37, 32'h10, "phy");
    wr(lwn_pkg::OFF_LINK_CTL, 32'h200);
    rd(lwn_pkg::OFF_LINK_CTL, 32'h200, 32'h0, "hw_autonomous_width_disable");
    rd(8'h18, 32'hffffffff, 32'h0, "unmapped");
    `CHK("rates", 2'h3, TX_RATES_O)
  endtask

  task t_lanes;
    train(8'hfd);
    `CHK("rev", 1'b1, TX_REVERSED_O)
    `CHK("pwid", 6'd4, TX_WIDTH_O)
    msg(1'b0, 6'd1, 1'b0, 1'b0);
    rd(lwn_pkg::OFF_LINK_STS, 32'h3f0, 32'h10, "nwid");
    train(8'hfd);
    msg(1'b0, 6'd4, 1'b0, 1'b0);
    train(8'hfd);
    `CHK("rev2", 1'b0, TX_REVERSED_O)
    `CHK("pwid2", 6'd1, TX_WIDTH_O)
  endtask

  task t_width;
    wr(lwn_pkg::OFF_PHY_STATE, 32'h1);
    wr(lwn_pkg::OFF_LINK_CAP, 32'h40);
    rd(lwn_pkg::OFF_LINK_CAP, 32'h3f0, 32'h80, "lock");
    wr(lwn_pkg::OFF_SW_CTL, 32'h1);
    wr(lwn_pkg::OFF_LINK_CAP, 32'h40);
    wr(lwn_pkg::OFF_LINK_CAP, 32'h30);
    rd(lwn_pkg::OFF_LINK_CAP, 32'h3f0, 32'h40, "unlock");
    train(8'hff);
    `CHK("maxw", 6'd4, TX_WIDTH_O)
    wr(lwn_pkg::OFF_LINK_CAP, 32'h80);
    for (int i = 0; i < 4; i++)
    begin
      train(8'hff);
      msg(1'b0, 6'd8 >> i, 1'b0, 1'b0);
      rd(lwn_pkg::OFF_LINK_STS, 32'h3f0, 32'h80 >> i, "width");
    end
  endtask

  task t_resize;
    msg(1'b1, 6'd4, 1'b0, 1'b0);
    rd(lwn_pkg::OFF_LINK_STS, 32'hc3f0, 32'h4040, "upcfg");
    wr(lwn_pkg::OFF_LINK_STS, 32'hc000);
    msg(1'b1, 6'd2, 1'b0, 1'b1);
    rd(lwn_pkg::OFF_LINK_STS, 32'hc3f0, 32'h8020, "auton");
    wr(lwn_pkg::OFF_LINK_STS, 32'hc000);
  endtask

  task t_speed;
    bring_up(2'b01);
    `CHK("gen1only", 1'b0, seen)
    rd(lwn_pkg::OFF_PHY_STATE, 32'h30, 32'h10, "prate1");
    wr(lwn_pkg::OFF_PHY_STATE, 32'h2);
    bring_up(2'b11);
    `CHK("inhibit", 1'b0, seen)
    rd(lwn_pkg::OFF_PHY_STATE, 32'h30, 32'h30, "prate2");
    wr(lwn_pkg::OFF_PHY_STATE, 32'h0);
    PORT_DOWNSTREAM_I <= 1'b0;
    bring_up(2'b11);
    `CHK("upstream", 1'b0, seen)
    PORT_DOWNSTREAM_I <= 1'b1;
    bring_up(2'b11);
    `CHK("auto", 1'b1, seen && g2)
    rd(lwn_pkg::OFF_LINK_STS, 32'h400f, 32'h2, "gen2");
  endtask

  task t_retrain;
    wr(lwn_pkg::OFF_LINK_CTL2, 32'h1);
    `CHK("adv1", 2'h1, TX_RATES_O)
    wr(lwn_pkg::OFF_LINK_CTL, 32'h20);
    wait_req();
    `CHK("down", 1'b1, seen && !g2)
    rd(lwn_pkg::OFF_LINK_STS, 32'h400f, 32'h4001, "gen1");
    wr(lwn_pkg::OFF_LINK_STS, 32'h4000);
    wr(lwn_pkg::OFF_LINK_CTL, 32'h20);
    wait_req();
    `CHK("same", 1'b0, seen)
    delay <= 4'd0;
    wr(lwn_pkg::OFF_LINK_CTL2, 32'h2);
    wr(lwn_pkg::OFF_LINK_CTL, 32'h20);
    wait_req();
    `CHK("upg", 1'b1, seen && g2)
    rd(lwn_pkg::OFF_LINK_STS, 32'h400f, 32'h4002, "regen2");
  endtask

  initial
  begin
    #400000;
    error_cnt++;
    stop_test();
  end

  initial
  begin
    RST_B_I = 1'b0;
    {AVS_READ_I, AVS_WRITE_I, LTSSM_DETECT_I, LTSSM_CONFIG_I} = '0;
    {LANE_NUM_FAIL_I, PARTNER_AUTON_I, LTSSM_L0_I, DL_ACTIVE_I} = '0;
    {PARTNER_SPEED_I, PARTNER_GEN2_I, RELIAB_DOWN_I} = '0;
    {gen2_cap, adv, ans, rsz, ans_rev, seen, g2} = '0;
    AVS_ADDRESS_I = 8'h0;
    AVS_WRITEDATA_I = 32'h0;
    AVS_BYTEENABLE_I = 4'hf;
    LANE_GOOD_I = 8'hff;
    PORT_DOWNSTREAM_I = 1'b1;
    ans_width = 6'h0;
    delay = 4'd5;
    repeat (6) @(posedge SYS_CLK_I);
    RST_B_I <= 1'b1;
    @(posedge SYS_CLK_I);
    t_reset();
    t_lanes();
    t_width();
    t_resize();
    t_speed();
    t_retrain();
    stop_test();
  end
endmodule
